//--- hw/mavs_params.svh
`ifndef MAVS_PARAMS_SVH
`define MAVS_PARAMS_SVH
// ==========================================================
// register map
`define MAVS_ADDR_W        12
`define MAVS_DATA_W        16
`define MAVS_A_SLOT_N      12'h00e
`define MAVS_A_SUM_THR     12'h054
`define MAVS_A_TEMP_COEF   12'h060
`define MAVS_PHASE_A_RMS_CURRENT_RAW_A      12'h1cc
`define MAVS_A_TEMP_CMD    12'hc01
`define MAVS_A_LP_ENTRY    12'hc03
`define MAVS_A_LP_EXIT     12'hc04
`define MAVS_A_AUX_CFG     12'h0a0
`define MAVS_A_NRMS        12'h0a2
`define MAVS_A_NVIRT       12'h0a3
`define MAVS_A_GAIN        12'h0b0
`define MAVS_A_LOW_CURRENT_GAIN     12'h0b1
`define MAVS_A_LOW_CURRENT_OFFSET     12'h0b2
`define MAVS_A_EGAIN       12'h0b3
`define MAVS_A_PA0         12'h0b4
`define MAVS_A_PA1         12'h0b5
`define MAVS_A_PA2         12'h0b6
`define MAVS_A_THR_UP      12'h0b7
`define MAVS_A_THR_LO      12'h0b8
`define MAVS_A_ENERGY      12'h0b9
`define MAVS_A_HOST_STAT   12'hf00
// ==========================================================
// fields and reset values
`define MAVS_AUX_EN_BIT    6
`define MAVS_AUX_REV_BIT   5
`define MAVS_AUX_SEL_HI    3
`define MAVS_SLOT_DIS_BIT  3
`define MAVS_SEL_SUM3      4'h9
`define MAVS_SEL_SUM4      4'hf
`define MAVS_SLOT_RST      16'h0068
`define MAVS_GAIN_UNITY    16'h4000
`define MAVS_GAIN_FRAC     14
`define MAVS_LOW_THR       16'h0400
`define MAVS_AVG_SHIFT     4
`define MAVS_LP_DIV        4'h8
`define MAVS_TEMP_SHIFT    16
`define MAVS_TEMP_OFS_Q16  40'sd17901158
`define MAVS_AP_COEF       16'sh2000
`endif

//--- hw/mavs_pkg.sv
`default_nettype none
package mavs_pkg;
  // processing steps of one sample set, gray along the path
  typedef enum logic [1:0] {
    MAVS_IDLE  = 2'b00,
    MAVS_ALIGN = 2'b01,
    MAVS_SUM   = 2'b11,
    MAVS_CMP   = 2'b10
  } mavs_proc_t;
endpackage
`default_nettype wire

//--- hw/mavs_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "mavs_params.svh"
interface mavs_if;
  logic                     rd;
  logic                     wr;
  logic [`MAVS_ADDR_W-1:0]  addr;
  logic [`MAVS_DATA_W-1:0]  wdata;
  logic [`MAVS_DATA_W-1:0]  rdata;
  logic                     irq;
  modport dev  (input rd, wr, addr, wdata, output rdata, irq);
  modport host (output rd, wr, addr, wdata, input rdata, irq);
endinterface
`default_nettype wire

//--- hw/mavs_allpass.sv
`timescale 1ns/10ps
`default_nettype none
`include "mavs_params.svh"
module mavs_allpass
  import mavs_pkg::*;
#(
  parameter logic signed [15:0] COEF = `MAVS_AP_COEF
)(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // sample stream
  input  wire logic               en,
  input  wire logic signed [15:0] x,
  output logic signed [15:0]      y
);
  logic signed [15:0] x_prev_r;
  logic signed [16:0] diff;
  logic signed [32:0] prod;
  logic signed [17:0] y_nxt;

  // first order allpass: y = c*(x - y1) + x1, delays by a fraction
  assign diff  = 17'(x) - 17'(y);
  assign prod  = 33'(diff) * 33'(COEF);
  assign y_nxt = 18'(prod >>> 15) + 18'(x_prev_r);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      x_prev_r <= '0;
      y        <= '0;
    end
    else if (en)
    begin
      x_prev_r <= x;
      y        <= y_nxt[15:0];
    end
  end
endmodule
`default_nettype wire

//--- hw/mavs_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "mavs_params.svh"
// Operation
// - sum current samples, never rms results
// - allpass align phase b, c, neutral
// - enable plus select 1001b gives three-term sum
// - neutral slot on, select 1111b: four-term
// - reverse bit subtracts neutral
// - keep accumulating; raw and converted result
// - irq when sum exceeds threshold
// - low power: clock from rc divided 8
// - low power keeps rms and ampere-hours only
// - low power entered only by host write
// - host reloads clock settings after entry
// - reading exit register leaves low power
// - temperature read starts conversion, degrees
// - temperature = raw*coef/2^16 - 273.15
// - gain 32 below low current threshold
// - low gain applied on top of gain
// - gains unity 0x4000, msb kept clear
// - host writes energy gain ratio times 2^14
// - host writes offset as negated zero reading
// - phase offset chosen by two thresholds
// - phase a raw rms at 0x1cc
// - aux enable runs rms on selected source
// - disabled slot takes no samples
module mavs_device
  import mavs_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // host link
  mavs_if.dev                     link,
  // sample set from the converter
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] cur_a,
  input  wire logic signed [15:0] cur_b,
  input  wire logic signed [15:0] cur_c,
  input  wire logic signed [15:0] cur_n,
  input  wire logic signed [15:0] volt_a,
  input  wire logic        [15:0] raw_temp,
  // analog front controls
  output logic                    lp_clk_select,
  output logic             [3:0]  lp_clk_divide,
  output logic                    neutral_slot_off,
  output logic                    range_gain32,
  output logic                    temp_convert_start,
  output logic             [15:0] phase_offset_applied
);
  // ========================================================
  // registers
  logic [15:0] aux_cfg_r, slot_n_r, sum_thr_r, temp_coef_r;
  logic [15:0] gain_r, low_current_gain_r, low_current_offset_r, egain_r;
  logic [15:0] pa_r [3];
  logic [15:0] thr_up_r, thr_lo_r;
  logic        lp_mode_r;
  logic [15:0] rdata_r;
  logic        wr_ok;
  logic [15:0] wmask;

  // gain fields keep their msb clear
  assign wmask = (link.addr == `MAVS_A_GAIN || link.addr == `MAVS_A_LOW_CURRENT_GAIN
                 || link.addr == `MAVS_A_EGAIN) ? 16'h7fff : 16'hffff;
  assign wr_ok = link.wr;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aux_cfg_r   <= 16'h0000;
      slot_n_r    <= `MAVS_SLOT_RST;
      sum_thr_r   <= 16'hffff;
      temp_coef_r <= 16'h0000;
      gain_r      <= `MAVS_GAIN_UNITY;
      low_current_gain_r   <= `MAVS_GAIN_UNITY;
      low_current_offset_r   <= 16'h0000;
      egain_r     <= `MAVS_GAIN_UNITY;
      pa_r[0]     <= 16'h0000;
      pa_r[1]     <= 16'h0000;
      pa_r[2]     <= 16'h0000;
      thr_up_r    <= 16'h0000;
      thr_lo_r    <= 16'h0000;
    end
    else if (wr_ok)
    begin
      case (link.addr)
        `MAVS_A_AUX_CFG:   aux_cfg_r   <= link.wdata;
        `MAVS_A_SLOT_N:    slot_n_r    <= link.wdata;
        `MAVS_A_SUM_THR:   sum_thr_r   <= link.wdata;
        `MAVS_A_TEMP_COEF: temp_coef_r <= link.wdata;
        `MAVS_A_GAIN:      gain_r      <= link.wdata & wmask;
        `MAVS_A_LOW_CURRENT_GAIN:   low_current_gain_r   <= link.wdata & wmask;
        `MAVS_A_LOW_CURRENT_OFFSET:   low_current_offset_r   <= link.wdata;
        `MAVS_A_EGAIN:     egain_r     <= link.wdata & wmask;
        `MAVS_A_PA0:       pa_r[0]     <= link.wdata;
        `MAVS_A_PA1:       pa_r[1]     <= link.wdata;
        `MAVS_A_PA2:       pa_r[2]     <= link.wdata;
        `MAVS_A_THR_UP:    thr_up_r    <= link.wdata;
        `MAVS_A_THR_LO:    thr_lo_r    <= link.wdata;
        default:           ;
      endcase
    end
  end

  // ========================================================
  // low power mode
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      lp_mode_r <= 1'b0;
    else if (link.wr && link.addr == `MAVS_A_LP_ENTRY && link.wdata[0])
      lp_mode_r <= 1'b1;
    else if (link.rd && link.addr == `MAVS_A_LP_EXIT)
      lp_mode_r <= 1'b0;
  end

  assign lp_clk_select = lp_mode_r;
  assign lp_clk_divide = `MAVS_LP_DIV;

  // ========================================================
  // vector sum datapath
  mavs_proc_t          st_r;
  logic                aux_on, sum4, neut_on;
  logic signed [15:0]  ap_in  [3];
  logic signed [15:0]  ap_out [3];
  logic signed [18:0]  sum_r;
  logic        [18:0]  sum_abs;
  logic        [19:0]  nacc_r;
  logic        [15:0]  nrms;
  logic                above_r, irq_r;

  assign neut_on  = !slot_n_r[`MAVS_SLOT_DIS_BIT];
  assign neutral_slot_off = !neut_on;
  assign aux_on   = aux_cfg_r[`MAVS_AUX_EN_BIT] && !lp_mode_r;
  assign sum4     = aux_cfg_r[`MAVS_AUX_SEL_HI:0] == `MAVS_SEL_SUM4;
  assign ap_in[0] = cur_b;
  assign ap_in[1] = cur_c;
  assign ap_in[2] = neut_on ? cur_n : 16'sh0000;

  // samples are staggered in time, so align b, c and n first
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_align
      mavs_allpass #(.COEF(`MAVS_AP_COEF)) u_ap (
        .clock   (clock),
        .sys_rst (sys_rst),
        .en      (sample_valid),
        .x       (ap_in[gi]),
        .y       (ap_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      st_r <= MAVS_IDLE;
    else
    begin
      case (st_r)
        MAVS_IDLE:  st_r <= sample_valid ? MAVS_ALIGN : MAVS_IDLE;
        MAVS_ALIGN: st_r <= MAVS_SUM;
        MAVS_SUM:   st_r <= MAVS_CMP;
        MAVS_CMP:   st_r <= MAVS_IDLE;
        default:    st_r <= MAVS_IDLE;
      endcase
    end
  end

  // instantaneous sum, never of rms values
  logic signed [15:0] cur_a_d_r;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cur_a_d_r <= '0;
    else if (sample_valid)
      cur_a_d_r <= cur_a;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sum_r <= '0;
    else if (st_r == MAVS_ALIGN)
    begin
      if (!sum4)
        sum_r <= 19'(cur_a_d_r) + 19'(ap_out[0]) + 19'(ap_out[1]);
      else if (aux_cfg_r[`MAVS_AUX_REV_BIT])
        sum_r <= 19'(cur_a_d_r) + 19'(ap_out[0]) + 19'(ap_out[1])
                 - 19'(ap_out[2]);
      else
        sum_r <= 19'(cur_a_d_r) + 19'(ap_out[0]) + 19'(ap_out[1])
                 + 19'(ap_out[2]);
    end
  end

  // rectified average stands in for rms; cheap, settles slowly
  assign sum_abs = sum_r[18] ? 19'(-sum_r) : 19'(sum_r);
  assign nrms    = nacc_r[19:4];

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      nacc_r <= '0;
    else if (st_r == MAVS_SUM && aux_on)
      nacc_r <= 20'(nacc_r - (nacc_r >> `MAVS_AVG_SHIFT)
                + 20'(sum_abs));
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      above_r <= 1'b0;
      irq_r   <= 1'b0;
    end
    else if (st_r == MAVS_CMP && aux_on)
    begin
      above_r <= nrms > sum_thr_r;
      irq_r   <= (nrms > sum_thr_r) && !above_r;
    end
    else
      irq_r <= 1'b0;
  end
  assign link.irq = irq_r;

  // ========================================================
  // phase a current calibration
  logic        [15:0] mag_a;
  logic        [31:0] lo_gain_p, gain_p, e_p;
  logic        [15:0] cur_corr;
  logic        [15:0] rms_current_raw_a_r;
  logic        [15:0] energy_r;
  logic        [31:0] eacc_r;

  assign mag_a        = cur_a[15] ? 16'(-cur_a) : 16'(cur_a);
  assign range_gain32 = mag_a < `MAVS_LOW_THR;
  assign lo_gain_p    = 32'(mag_a) * 32'(low_current_gain_r);
  assign gain_p       = range_gain32
                        ? 32'(lo_gain_p[29:14]) * 32'(gain_r)
                        : 32'(mag_a) * 32'(gain_r);
  assign cur_corr     = range_gain32 ? gain_p[29:14] + low_current_offset_r
                                     : gain_p[29:14];
  assign e_p          = lp_mode_r ? 32'(cur_corr)
                        : 32'(cur_corr) * 32'(egain_r);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rms_current_raw_a_r <= '0;
      eacc_r   <= '0;
    end
    else if (sample_valid)
    begin
      rms_current_raw_a_r <= 16'(rms_current_raw_a_r - (rms_current_raw_a_r >> `MAVS_AVG_SHIFT)
                  + (cur_corr >> `MAVS_AVG_SHIFT));
      eacc_r   <= lp_mode_r ? eacc_r + e_p
                  : eacc_r + (volt_a[15] ? 32'h0 : e_p >> 14);
    end
  end
  assign energy_r = eacc_r[31:16];

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      phase_offset_applied <= '0;
    else if (rms_current_raw_a_r >= thr_up_r)
      phase_offset_applied <= pa_r[0];
    else if (rms_current_raw_a_r >= thr_lo_r)
      phase_offset_applied <= pa_r[1];
    else
      phase_offset_applied <= pa_r[2];
  end

  // ========================================================
  // readback
  logic signed [39:0] temp_q16;
  logic        [31:0] nvirt_p;

  assign temp_q16 = 40'(32'(raw_temp) * 32'(temp_coef_r))
                    - `MAVS_TEMP_OFS_Q16;
  assign nvirt_p  = 32'(nrms) * 32'(gain_r);
  assign temp_convert_start = link.rd && link.addr == `MAVS_A_TEMP_CMD;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata_r <= '0;
    else if (link.rd)
    begin
      case (link.addr)
        `MAVS_A_AUX_CFG:   rdata_r <= aux_cfg_r;
        `MAVS_A_SLOT_N:    rdata_r <= slot_n_r;
        `MAVS_A_SUM_THR:   rdata_r <= sum_thr_r;
        `MAVS_A_TEMP_COEF: rdata_r <= temp_coef_r;
        `MAVS_A_GAIN:      rdata_r <= gain_r;
        `MAVS_A_LOW_CURRENT_GAIN:   rdata_r <= low_current_gain_r;
        `MAVS_A_LOW_CURRENT_OFFSET:   rdata_r <= low_current_offset_r;
        `MAVS_A_EGAIN:     rdata_r <= egain_r;
        `MAVS_A_PA0:       rdata_r <= pa_r[0];
        `MAVS_A_PA1:       rdata_r <= pa_r[1];
        `MAVS_A_PA2:       rdata_r <= pa_r[2];
        `MAVS_A_THR_UP:    rdata_r <= thr_up_r;
        `MAVS_A_THR_LO:    rdata_r <= thr_lo_r;
        `MAVS_A_NRMS:      rdata_r <= nrms;
        `MAVS_A_NVIRT:     rdata_r <= nvirt_p[29:14];
        `MAVS_PHASE_A_RMS_CURRENT_RAW_A:    rdata_r <= rms_current_raw_a_r;
        `MAVS_A_ENERGY:    rdata_r <= energy_r;
        `MAVS_A_LP_ENTRY:  rdata_r <= {15'h0000, lp_mode_r};
        `MAVS_A_LP_EXIT:   rdata_r <= {15'h0000, lp_mode_r};
        // conversion result in whole degrees
        `MAVS_A_TEMP_CMD:  rdata_r <= temp_q16[31:16];
        default:           rdata_r <= 16'h0000;
      endcase
    end
  end
  assign link.rdata = rdata_r;
endmodule
`default_nettype wire

//--- hw/mavs_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "mavs_params.svh"
module mavs_host
  import mavs_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // software port
  input  wire logic [`MAVS_ADDR_W-1:0] sw_addr,
  input  wire logic [`MAVS_DATA_W-1:0] sw_wdata,
  input  wire logic                    sw_wr,
  input  wire logic                    sw_rd,
  output logic      [`MAVS_DATA_W-1:0] sw_rdata,
  output logic                         irq_pending,
  // device link
  mavs_if.host                         link
);
  logic        local_sel, stat_rd_r, gain_wr;
  logic        irq_seen_r, reload_r, lp_r;
  logic [15:0] stat;

  assign local_sel = sw_addr == `MAVS_A_HOST_STAT;
  assign gain_wr   = sw_addr == `MAVS_A_GAIN || sw_addr == `MAVS_A_LOW_CURRENT_GAIN
                     || sw_addr == `MAVS_A_EGAIN;

  // strobes pass straight through so read data keeps its one-cycle slot
  assign link.wr    = sw_wr && !local_sel;
  assign link.rd    = sw_rd && !local_sel;
  assign link.addr  = sw_addr;
  assign link.wdata = gain_wr ? {1'b0, sw_wdata[14:0]} : sw_wdata;

  // ========================================================
  // local status: irq sticky, reload pending, mode shadow
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq_seen_r <= 1'b0;
    else if (link.irq)
      irq_seen_r <= 1'b1; // set wins over clear
    else if (sw_wr && local_sel && sw_wdata[0])
      irq_seen_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      reload_r <= 1'b0;
      lp_r     <= 1'b0;
    end
    else if (link.wr && sw_addr == `MAVS_A_LP_ENTRY && sw_wdata[0])
    begin
      reload_r <= 1'b1;
      lp_r     <= 1'b1;
    end
    else if (link.rd && sw_addr == `MAVS_A_LP_EXIT)
    begin
      lp_r     <= 1'b0;
      reload_r <= 1'b0;
    end
    else if (sw_wr && local_sel && sw_wdata[1])
      reload_r <= 1'b0; // software reports clock settings reloaded
  end

  assign stat        = {13'h0000, lp_r, reload_r, irq_seen_r};
  assign irq_pending = irq_seen_r;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stat_rd_r <= 1'b0;
    else
      stat_rd_r <= sw_rd && local_sel;
  end

  logic [15:0] stat_r;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stat_r <= '0;
    else
      stat_r <= stat;
  end

  assign sw_rdata = stat_rd_r ? stat_r : link.rdata;
endmodule
`default_nettype wire

//--- verification/mavs_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "mavs_params.svh"
module mavs_checker
  import mavs_pkg::*;
(
  // clock and reset
  input wire logic                    clock,
  input wire logic                    sys_rst,
  // register link
  input wire logic                    rd,
  input wire logic                    wr,
  input wire logic [`MAVS_ADDR_W-1:0] addr,
  input wire logic [`MAVS_DATA_W-1:0] wdata,
  input wire logic [`MAVS_DATA_W-1:0] rdata,
  input wire logic                    irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ======
  // shadows of what the host wrote
  logic [15:0] thr_r;
  logic [15:0] coef_r;
  logic [15:0] cfg_r;
  logic [15:0] gain_r;
  logic        cfg_ok_r;
  logic        gain_ok_r;
  logic        lp_r;
  logic [3:0]  quiet_r;
  logic        quiet;
  // irq may still be in flight for a few cycles, so quiet is counted
  assign quiet = lp_r || (thr_r == 16'hffff) ||
                 (cfg_ok_r && !cfg_r[`MAVS_AUX_EN_BIT]);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      thr_r     <= 16'hffff;
      coef_r    <= 16'h0000;
      cfg_r     <= 16'h0000;
      gain_r    <= 16'h0000;
      cfg_ok_r  <= 1'b0;
      gain_ok_r <= 1'b0;
      lp_r      <= 1'b0;
    end
    else
    begin
      if (wr && addr == `MAVS_A_SUM_THR) thr_r <= wdata;
      if (wr && addr == `MAVS_A_TEMP_COEF) coef_r <= wdata;
      if (wr && addr == `MAVS_A_AUX_CFG) cfg_r <= wdata;
      if (wr && addr == `MAVS_A_AUX_CFG) cfg_ok_r <= 1'b1;
      if (wr && addr == `MAVS_A_GAIN) gain_r <= wdata;
      if (wr && addr == `MAVS_A_GAIN) gain_ok_r <= 1'b1;
      if (wr && addr == `MAVS_A_LP_ENTRY && wdata[0]) lp_r <= 1'b1;
      if (rd && addr == `MAVS_A_LP_EXIT) lp_r <= 1'b0;
    end
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst || !quiet)
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
  end
  // ======
  // assertions
  chk_thr_readback: assert property (
    rd && addr == `MAVS_A_SUM_THR |=> rdata == thr_r)
    else $error("threshold read differs from last write");
  chk_coef_readback: assert property (
    rd && addr == `MAVS_A_TEMP_COEF |=> rdata == coef_r)
    else $error("temperature coefficient read differs");
  chk_cfg_readback: assert property (
    rd && addr == `MAVS_A_AUX_CFG && cfg_ok_r |=> rdata == cfg_r)
    else $error("aux configuration read differs");
  chk_gain_readback: assert property (
    rd && addr == `MAVS_A_GAIN && gain_ok_r |=> rdata == gain_r)
    else $error("gain read differs from last write");
  chk_lp_mode_bit: assert property (
    rd && addr == `MAVS_A_LP_ENTRY |=> rdata[0] == lp_r)
    else $error("low power mode bit wrong");
  chk_lp_exit_read: assert property (
    rd && addr == `MAVS_A_LP_EXIT ##1 !wr ##1 rd && addr == `MAVS_A_LP_ENTRY
    |=> !rdata[0])
    else $error("low power mode not left after exit read");
  chk_irq_spacing: assert property (
    irq |=> !irq [*3])
    else $error("irq longer than one pulse per processing cycle");
  chk_irq_quiet: assert property (
    quiet_r >= 4'h8 |-> !irq)
    else $error("irq while disabled, low power or at max threshold");
endmodule
`default_nettype wire

//--- verification/mavs_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "mavs_params.svh"
module mavs_test;
  logic               clock;
  logic               sys_rst;
  logic [11:0]        sw_addr;
  logic [15:0]        sw_wdata;
  logic               sw_wr;
  logic               sw_rd;
  logic [15:0]        sw_rdata;
  logic               irq_pending;
  logic               sample_valid;
  logic signed [15:0] cur_a;
  logic signed [15:0] cur_b;
  logic signed [15:0] cur_c;
  logic signed [15:0] cur_n;
  logic signed [15:0] volt_a;
  logic [15:0]        raw_temp;
  logic               lp_clk_select;
  logic [3:0]         lp_clk_divide;
  logic               neutral_slot_off;
  logic               range_gain32;
  logic               temp_convert_start;
  logic [15:0]        phase_offset_applied;
  int                 n_errors;
  int                 samples_checked;
  logic [15:0]        rv;
  logic [39:0]        t40;
  logic [15:0]        codes [3] = '{16'h0049, 16'h004f, 16'h006f};
  logic [15:0]        ivals [5] = '{16'h03ff, 16'h0400, 16'hfc01,
                                    16'hfc00, 16'h0000};
  logic               gvals [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  mavs_if i_mavs_if ();
  mavs_device i_mavs_device (.clock(clock), .sys_rst(sys_rst),
    .link(i_mavs_if.dev), .sample_valid(sample_valid), .cur_a(cur_a),
    .cur_b(cur_b), .cur_c(cur_c), .cur_n(cur_n), .volt_a(volt_a),
    .raw_temp(raw_temp), .lp_clk_select(lp_clk_select),
    .lp_clk_divide(lp_clk_divide), .neutral_slot_off(neutral_slot_off),
    .range_gain32(range_gain32), .temp_convert_start(temp_convert_start),
    .phase_offset_applied(phase_offset_applied));
  mavs_host i_mavs_host (.clock(clock), .sys_rst(sys_rst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq_pending(irq_pending),
    .link(i_mavs_if.host));
  mavs_checker i_mavs_checker (.clock(clock), .sys_rst(sys_rst),
    .rd(i_mavs_if.rd), .wr(i_mavs_if.wr), .addr(i_mavs_if.addr),
    .wdata(i_mavs_if.wdata), .rdata(i_mavs_if.rdata), .irq(i_mavs_if.irq));
  // ======
  // access tasks
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clock);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    #1;
    check("convert start", {15'h0000, temp_convert_start},
          {15'h0000, a == `MAVS_A_TEMP_CMD});
    @(posedge clock);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  // samples spaced five cycles, one more than the four the sample path needs
  task automatic feed(input logic [15:0] a, input int n);
    repeat (n)
    begin
      @(posedge clock);
      sample_valid <= 1'b1;
      cur_a        <= a;
      cur_b        <= 16'h0000 - a;
      cur_c        <= a;
      cur_n        <= a;
      volt_a       <= a;
      @(posedge clock);
      sample_valid <= 1'b0;
      repeat (3) @(posedge clock);
    end
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ======
  // clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
  // ======
  // tests
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    {sw_wr, sw_rd, sample_valid} = 3'h0;
    {sw_addr, sw_wdata, cur_a, cur_b, cur_c, cur_n, volt_a} = '0;
    raw_temp = 16'h1000;
    sys_rst = 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    reg_rd(`MAVS_A_TEMP_COEF, rv);
    check("coef reset", rv, 16'h0000);
    reg_rd(`MAVS_A_SUM_THR, rv);
    check("threshold reset", rv, 16'hffff);
    check("slot off", {15'h0000, neutral_slot_off}, 16'h0001);
    foreach (codes[i])
    begin
      reg_wr(`MAVS_A_AUX_CFG, codes[i]);
      reg_rd(`MAVS_A_AUX_CFG, rv);
      check("aux config", rv, codes[i]);
    end
    reg_wr(`MAVS_A_GAIN, `MAVS_GAIN_UNITY);
    reg_rd(`MAVS_A_GAIN, rv);
    check("gain", rv, 16'h4000);
    reg_wr(`MAVS_A_SLOT_N, 16'h0060);
    check("slot on", {15'h0000, neutral_slot_off}, 16'h0000);
    reg_wr(`MAVS_A_TEMP_COEF, 16'h12a2);
    reg_rd(`MAVS_A_TEMP_CMD, rv);
    t40 = 40'd4096 * 40'd4770 - 40'd17901158;
    check("temperature", rv, t40[31:16]);
    foreach (ivals[i])
    begin
      @(posedge clock);
      cur_a <= ivals[i];
      #1;
      check("gain32", {15'h0000, range_gain32}, {15'h0000, gvals[i]});
    end
    // low power: a zero write and traffic must not enter it
    reg_wr(`MAVS_A_AUX_CFG, 16'h0049);
    reg_wr(`MAVS_A_SUM_THR, 16'h0010);
    reg_wr(`MAVS_A_LP_ENTRY, 16'h0000);
    feed(16'h0000, 2);
    check("lp kept off", {15'h0000, lp_clk_select}, 16'h0000);
    reg_wr(`MAVS_A_LP_ENTRY, 16'h0001);
    check("lp on", {15'h0000, lp_clk_select}, 16'h0001);
    check("lp divide", {12'h000, lp_clk_divide}, 16'h0008);
    reg_rd(`MAVS_A_HOST_STAT, rv);
    check("reload pending", {15'h0000, rv[1]}, 16'h0001);
    reg_rd(`MAVS_A_LP_ENTRY, rv);
    check("lp bit set", rv, 16'h0001);
    feed(16'h1000, 4);
    check("lp no irq", {15'h0000, irq_pending}, 16'h0000);
    reg_rd(`MAVS_A_LP_EXIT, rv);
    check("lp off", {15'h0000, lp_clk_select}, 16'h0000);
    reg_rd(`MAVS_A_LP_ENTRY, rv);
    check("lp bit clear", rv, 16'h0000);
    // vector sum threshold, one irq per crossing
    feed(16'h1000, 4);
    check("irq", {15'h0000, irq_pending}, 16'h0001);
    reg_rd(`MAVS_A_NRMS, rv);
    check("sum above", {15'h0000, rv > 16'h0010}, 16'h0001);
    reg_rd(`MAVS_A_HOST_STAT, rv);
    check("irq status", {15'h0000, rv[0]}, 16'h0001);
    reg_wr(`MAVS_A_HOST_STAT, 16'h0001);
    feed(16'h1000, 4);
    check("no re-irq", {15'h0000, irq_pending}, 16'h0000);
    feed(16'h0000, 100);
    feed(16'h1000, 4);
    check("re-irq", {15'h0000, irq_pending}, 16'h0001);
    reg_wr(`MAVS_A_AUX_CFG, 16'h0009);
    reg_wr(`MAVS_A_HOST_STAT, 16'h0001);
    feed(16'h0000, 100);
    feed(16'h1000, 4);
    check("aux off", {15'h0000, irq_pending}, 16'h0000);
    // four-term sum; neutral follows phase c, so reversing cancels it
    reg_wr(`MAVS_A_AUX_CFG, 16'h006f);
    feed(16'h1000, 200);
    reg_rd(`MAVS_A_NRMS, rv);
    check("reversed sum", rv, 16'h0000);
    reg_wr(`MAVS_A_AUX_CFG, 16'h004f);
    feed(16'h1000, 4);
    check("four-term irq", {15'h0000, irq_pending}, 16'h0001);
    reg_rd(`MAVS_PHASE_A_RMS_CURRENT_RAW_A, rv);
    check("rms_current_raw a", {15'h0000, rv != 16'h0000}, 16'h0001);
    // phase offset follows the current against two thresholds
    reg_wr(`MAVS_A_PA0, 16'h0011);
    reg_wr(`MAVS_A_PA1, 16'h0022);
    reg_wr(`MAVS_A_PA2, 16'h0033);
    @(posedge clock);
    #1;
    check("offset high", phase_offset_applied, 16'h0011);
    reg_wr(`MAVS_A_THR_UP, 16'hffff);
    @(posedge clock);
    #1;
    check("offset mid", phase_offset_applied, 16'h0022);
    reg_wr(`MAVS_A_THR_LO, 16'hffff);
    @(posedge clock);
    #1;
    check("offset low", phase_offset_applied, 16'h0033);
    // calibration words as software programs them
    reg_wr(`MAVS_A_EGAIN, 16'h4000);
    reg_rd(`MAVS_A_EGAIN, rv);
    check("energy gain", rv, 16'h4000);
    reg_wr(`MAVS_A_LOW_CURRENT_GAIN, 16'hffff);
    reg_rd(`MAVS_A_LOW_CURRENT_GAIN, rv);
    check("low gain msb", rv, 16'h7fff);
    reg_wr(`MAVS_A_LOW_CURRENT_OFFSET, 16'h0000 - 16'h0113);
    reg_rd(`MAVS_A_LOW_CURRENT_OFFSET, rv);
    check("low offset", rv, 16'hfeed);
    tally_and_finish();
  end
endmodule
`default_nettype wire
